// file: rtl/timer8_pkg.sv
// constants and types shared by the 8-bit waveform timer
package timer8_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] CTRL_OFS   = 5'h00;
	localparam logic [4:0] COUNT_OFS  = 5'h04;
	localparam logic [4:0] CMPA_OFS   = 5'h08;
	localparam logic [4:0] CMPB_OFS   = 5'h0C;
	localparam logic [4:0] STATUS_OFS = 5'h10;
	// ----------------------------------------------------------------
	// field positions and masks
	// ----------------------------------------------------------------
	localparam int         MODE_LSB   = 0;
	localparam int         MODE_HIGH  = 2;
	localparam int         ACT_B_LSB  = 4;
	localparam int         ACT_A_LSB  = 6;
	localparam logic [7:0] CTRL_WMASK = 8'hF7;
	localparam int         OVF_BIT    = 0;
	localparam int         MFA_BIT    = 1;
	localparam int         MFB_BIT    = 2;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CMP_RST   = 8'h00;
	// ----------------------------------------------------------------
	// counter extremes, mode and action codes
	// ----------------------------------------------------------------
	localparam logic [7:0] BOTTOM       = 8'h00;
	localparam logic [7:0] MAX          = 8'hFF;
	localparam logic [2:0] WGM_NORMAL   = 3'h0;
	localparam logic [2:0] WGM_PHASE_FF = 3'h1;
	localparam logic [2:0] WGM_CTC      = 3'h2;
	localparam logic [2:0] WGM_FAST_FF  = 3'h3;
	localparam logic [2:0] WGM_PHASE_A  = 3'h5;
	localparam logic [2:0] WGM_FAST_A   = 3'h7;
	localparam logic [1:0] ACT_OFF      = 2'h0;
	localparam logic [1:0] ACT_TOGGLE   = 2'h1;
	localparam logic [1:0] ACT_NONINV   = 2'h2;
	localparam logic [1:0] ACT_INV      = 2'h3;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_DECERR  = 2'h3;

	typedef enum logic [3:0] {
		MODE_NORMAL = 4'h1,
		MODE_CTC    = 4'h2,
		MODE_FAST   = 4'h4,
		MODE_PHASE  = 4'h8
	} mode_t;
endpackage

// file: rtl/timer8_waveform_modes.sv
// 8-bit timer with normal, clear-on-match, fast and phase-correct waveform modes
//
// Notes on behaviour
// (R1) mode field alone picks the count sequence; actions only shape outputs
// (R2) mode 0 counts up only, wraps 0xFF to 0x00, never clears
// (R3) normal mode sets overflow as count becomes zero; only set by hardware, cleared by a status write
// (R4) mode 2 clears the counter on a match with compare A
// (R5) clear-on-match compare A is unbuffered; below count means run to wrap
// (R6) clear-on-match with action 1 toggles output A on every match
// (R7) clear-on-match sets overflow when passing from maximum to 0x00
// (R8) modes 3 and 7 are fast PWM; top 0xFF or compare A
// (R9) fast PWM clears the counter on the tick after it matches top
// (R10) fast PWM action 2 clears on match, sets at bottom; 3 the reverse
// (R11) fast PWM sets overflow each time the counter reaches top
// (R12) fast PWM action 1 toggles output A only with high mode bit; B never
// (R13) fast PWM compare at bottom spikes per MAX+1 ticks; at max constant
// (R14) fast PWM uses double buffered compare values
// (R15) modes 1 and 5 are dual-slope PWM; top 0xFF or compare A
// (R16) dual-slope reverses at top, holding top one tick
// (R17) dual-slope action 2 clears on up match, sets on down; 3 reverse
// (R18) dual-slope sets overflow each time the counter reaches bottom
// (R19) dual-slope action 1 toggles output A only with high mode bit
// (R20) dual-slope compare at bottom gives constant low, at max high
// (R21) dual-slope output moves without match at top for symmetry
// (R22) far side enables the pin driver before the wave is visible
// (R23) a compare equality sets its match flag on the next tick
// (R24) a count write blocks all matches in the next tick
// (R25) PWM compare updates take effect only at top
// (R26) undefined mode values count like normal mode
`timescale 1ns/1ps
module timer8_waveform_modes (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        timer_tick_i,
	input  wire logic [4:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [4:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             wave_out_a_o,
	output logic             wave_out_b_o,
	output logic             wave_en_a_o,
	output logic             wave_en_b_o,
	output logic             overflow_flag_o,
	output logic             match_flag_a_o,
	output logic             match_flag_b_o
);
	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		return a[4:2] == o[4:2];
	endfunction

	function automatic timer8_pkg::mode_t decode(input logic [2:0] w);
		unique case (w)
			timer8_pkg::WGM_CTC:      return timer8_pkg::MODE_CTC;
			timer8_pkg::WGM_FAST_FF,
			timer8_pkg::WGM_FAST_A:   return timer8_pkg::MODE_FAST;
			timer8_pkg::WGM_PHASE_FF,
			timer8_pkg::WGM_PHASE_A:  return timer8_pkg::MODE_PHASE;
			default:                  return timer8_pkg::MODE_NORMAL; // R26
		endcase
	endfunction

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------------------------------
	// bus slave state
	// ----------------------------------------------------------------
	logic        awready;
	logic        wready;
	logic        aw_held;
	logic        w_held;
	logic [4:0]  aw_addr;
	logic [7:0]  w_byte;
	logic        w_lane0;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        arready;
	logic        rvalid;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        next_awready;
	logic        next_wready;
	logic        next_aw_held;
	logic        next_w_held;
	logic [4:0]  next_aw_addr;
	logic [7:0]  next_w_byte;
	logic        next_w_lane0;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        wr_fire;
	logic        wr_ctrl;
	logic        wr_count;
	logic        wr_cmpa;
	logic        wr_cmpb;
	logic        wr_status;

	// ----------------------------------------------------------------
	// timer state
	// ----------------------------------------------------------------
	logic [7:0]          ctrl;
	logic [7:0]          cnt;
	logic                dir_down;
	logic                block;
	logic                ovf;
	logic                pend     [2];
	logic                mflag    [2];
	logic [7:0]          cmp_buf  [2];
	logic [7:0]          cmp_act  [2];
	logic                wave     [2];
	logic                wave_en  [2];
	logic [7:0]          next_ctrl;
	logic [7:0]          next_cnt;
	logic                next_dir_down;
	logic                next_block;
	logic                next_ovf;
	logic                next_pend    [2];
	logic                next_mflag   [2];
	logic [7:0]          next_cmp_buf [2];
	logic [7:0]          next_cmp_act [2];
	timer8_pkg::mode_t   mode;
	logic                pwm;
	logic [7:0]          top;
	logic [7:0]          top_new;
	logic                at_top;
	logic                up_now;
	logic                tick_eff;
	logic                match    [2];
	logic                mev      [2];
	logic [1:0]          act      [2];
	logic [7:0]          cnt_step;
	logic                dir_step;
	logic                ovf_ev;

	// ----------------------------------------------------------------
	// bus slave: address and data may arrive in either order
	// ----------------------------------------------------------------
	assign wr_fire   = aw_held && w_held && !bvalid;
	assign wr_ctrl   = wr_fire && w_lane0 && hit(aw_addr, timer8_pkg::CTRL_OFS);
	assign wr_count  = wr_fire && w_lane0 && hit(aw_addr, timer8_pkg::COUNT_OFS);
	assign wr_cmpa   = wr_fire && w_lane0 && hit(aw_addr, timer8_pkg::CMPA_OFS);
	assign wr_cmpb   = wr_fire && w_lane0 && hit(aw_addr, timer8_pkg::CMPB_OFS);
	assign wr_status = wr_fire && w_lane0 && hit(aw_addr, timer8_pkg::STATUS_OFS);

	always_comb begin
		logic [7:0] rd;
		logic       mapped;
		rd           = 8'h00;
		mapped       = 1'b1;
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (s_axi_bready_i && bvalid) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr[4:2] > timer8_pkg::STATUS_OFS[4:2]) ? timer8_pkg::RESP_DECERR
				: timer8_pkg::RESP_OKAY;
		end
		if (s_axi_awvalid_i && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready) begin
			next_w_held  = 1'b1;
			next_w_byte  = s_axi_wdata_i[7:0];
			next_w_lane0 = s_axi_wstrb_i[0];
		end
		// only one answer outstanding; a new request waits for the old one
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
		if (hit(s_axi_araddr_i, timer8_pkg::CTRL_OFS)) begin
			rd = ctrl;
		end else if (hit(s_axi_araddr_i, timer8_pkg::COUNT_OFS)) begin
			rd = cnt;
		end else if (hit(s_axi_araddr_i, timer8_pkg::CMPA_OFS)) begin
			rd = cmp_buf[0];
		end else if (hit(s_axi_araddr_i, timer8_pkg::CMPB_OFS)) begin
			rd = cmp_buf[1];
		end else if (hit(s_axi_araddr_i, timer8_pkg::STATUS_OFS)) begin
			rd = {5'h00, mflag[1], mflag[0], ovf};
		end else begin
			mapped = 1'b0;
		end
		if (s_axi_rready_i && rvalid) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid_i && arready) begin
			next_rvalid  = 1'b1;
			next_arready = 1'b0;
			next_rdata   = {24'h000000, rd};
			next_rresp   = mapped ? timer8_pkg::RESP_OKAY : timer8_pkg::RESP_DECERR;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 5'h00;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= timer8_pkg::RESP_OKAY;
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= timer8_pkg::RESP_OKAY;
		end else begin
			awready <= next_awready;
			wready  <= next_wready;
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_addr <= next_aw_addr;
			w_byte  <= next_w_byte;
			w_lane0 <= next_w_lane0;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// counter sequence
	// ----------------------------------------------------------------
	assign mode     = decode(ctrl[timer8_pkg::MODE_LSB +: 3]); // R1
	assign pwm      = (mode == timer8_pkg::MODE_FAST) || (mode == timer8_pkg::MODE_PHASE);
	assign act[0]   = ctrl[timer8_pkg::ACT_A_LSB +: 2];
	assign act[1]   = ctrl[timer8_pkg::ACT_B_LSB +: 2];
	assign tick_eff = timer_tick_i && !wr_count;
	assign at_top   = cnt == top;
	assign up_now   = (cnt == timer8_pkg::BOTTOM) || (!dir_down && !at_top);
	assign top_new  = ctrl[timer8_pkg::MODE_HIGH] ? cmp_buf[0] : timer8_pkg::MAX;

	always_comb begin
		top      = timer8_pkg::MAX;
		cnt_step = cnt + 8'h01;
		dir_step = dir_down;
		ovf_ev   = 1'b0;
		unique case (mode)
			timer8_pkg::MODE_NORMAL: begin
				ovf_ev = cnt == timer8_pkg::MAX; // R2 R3
			end
			timer8_pkg::MODE_CTC: begin
				top = cmp_act[0];
				if (match[0]) begin
					cnt_step = timer8_pkg::BOTTOM; // R4
				end
				ovf_ev = cnt == timer8_pkg::MAX; // R5 R7
			end
			timer8_pkg::MODE_FAST: begin
				top = ctrl[timer8_pkg::MODE_HIGH] ? cmp_act[0] : timer8_pkg::MAX; // R8
				if (at_top) begin
					cnt_step = timer8_pkg::BOTTOM; // R9
				end
				ovf_ev = at_top; // R11
			end
			timer8_pkg::MODE_PHASE: begin
				top = ctrl[timer8_pkg::MODE_HIGH] ? cmp_act[0] : timer8_pkg::MAX; // R15
				if (!dir_down && cnt >= top) begin
					dir_step = 1'b1; // R16
					cnt_step = (cnt == timer8_pkg::BOTTOM) ? cnt : cnt - 8'h01;
				end else if (dir_down && cnt == timer8_pkg::BOTTOM) begin
					dir_step = 1'b0;
				end else if (dir_down) begin
					cnt_step = cnt - 8'h01;
				end
				ovf_ev = (cnt_step == timer8_pkg::BOTTOM) && (cnt != timer8_pkg::BOTTOM); // R18
			end
		endcase
	end

	always_comb begin
		next_ctrl     = ctrl;
		next_cnt      = cnt;
		next_dir_down = dir_down;
		next_block    = block;
		next_ovf      = ovf;
		next_pend     = pend;
		next_mflag    = mflag;
		next_cmp_buf  = cmp_buf;
		next_cmp_act  = cmp_act;
		if (wr_ctrl) begin
			next_ctrl = w_byte & timer8_pkg::CTRL_WMASK;
		end
		if (wr_cmpa) begin
			next_cmp_buf[0] = w_byte;
		end
		if (wr_cmpb) begin
			next_cmp_buf[1] = w_byte;
		end
		// clear first so that a same-cycle hardware set wins
		if (wr_status) begin
			next_ovf      = ovf && !w_byte[timer8_pkg::OVF_BIT];
			next_mflag[0] = mflag[0] && !w_byte[timer8_pkg::MFA_BIT];
			next_mflag[1] = mflag[1] && !w_byte[timer8_pkg::MFB_BIT];
		end
		if (tick_eff) begin
			next_cnt      = cnt_step;
			next_dir_down = dir_step;
			next_block    = 1'b0;
			if (ovf_ev) begin
				next_ovf = 1'b1;
			end
			for (int i = 0; i < 2; i++) begin
				next_pend[i] = match[i];
				if (pend[i]) begin
					next_mflag[i] = 1'b1; // R23
				end
				if (pwm && at_top) begin
					next_cmp_act[i] = cmp_buf[i]; // R14 R25
				end
			end
		end
		if (!pwm) begin
			next_cmp_act = next_cmp_buf; // R5
		end
		if (wr_count) begin
			next_cnt   = w_byte;
			next_block = 1'b1; // R24
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl     <= timer8_pkg::CTRL_RST;
			cnt      <= timer8_pkg::COUNT_RST;
			dir_down <= 1'b0;
			block    <= 1'b0;
			ovf      <= 1'b0;
			pend     <= '{1'b0, 1'b0};
			mflag    <= '{1'b0, 1'b0};
			cmp_buf  <= '{timer8_pkg::CMP_RST, timer8_pkg::CMP_RST};
			cmp_act  <= '{timer8_pkg::CMP_RST, timer8_pkg::CMP_RST};
		end else begin
			ctrl     <= next_ctrl;
			cnt      <= next_cnt;
			dir_down <= next_dir_down;
			block    <= next_block;
			ovf      <= next_ovf;
			pend     <= next_pend;
			mflag    <= next_mflag;
			cmp_buf  <= next_cmp_buf;
			cmp_act  <= next_cmp_act;
		end
	end

	// ----------------------------------------------------------------
	// waveform generators, one per compare channel
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_chan
		localparam bit IS_A = (i == 0);
		logic tog_ok;
		logic next_wave;
		logic next_en;

		assign match[i] = (cnt == cmp_act[i]) && !block; // R24
		assign mev[i]   = tick_eff && match[i];
		// toggle in PWM only on A with the high mode bit; B treats it as reserved
		assign tog_ok   = IS_A && ctrl[timer8_pkg::MODE_HIGH]; // R12 R19

		always_comb begin
			next_wave = wave[i];
			next_en   = (act[i] != timer8_pkg::ACT_OFF) && !(pwm && act[i] == timer8_pkg::ACT_TOGGLE && !tog_ok);
			if (tick_eff) begin
				unique case (mode)
					timer8_pkg::MODE_NORMAL,
					timer8_pkg::MODE_CTC: begin
						if (mev[i] && act[i] == timer8_pkg::ACT_TOGGLE) begin
							next_wave = !wave[i]; // R6
						end else if (mev[i] && act[i][1]) begin
							next_wave = act[i][0];
						end
					end
					timer8_pkg::MODE_FAST: begin
						if (act[i][1] && at_top) begin
							next_wave = !act[i][0]; // R10 R13
						end else if (act[i][1] && mev[i] && cmp_act[i] != top) begin
							next_wave = act[i][0]; // R10
						end else if (act[i] == timer8_pkg::ACT_TOGGLE && tog_ok && mev[i]) begin
							next_wave = !wave[i]; // R12
						end
					end
					timer8_pkg::MODE_PHASE: begin
						// at the turn take the up-match level so both slopes mirror
						if (act[i][1] && at_top && !dir_down) begin
							next_wave = (cmp_buf[i] == top_new) ? !act[i][0] : act[i][0]; // R20 R21
						end else if (act[i][1] && mev[i] && cmp_act[i] != top) begin
							next_wave = up_now ? act[i][0] : !act[i][0]; // R17 R20
						end else if (act[i] == timer8_pkg::ACT_TOGGLE && tog_ok && mev[i]) begin
							next_wave = !wave[i]; // R19
						end
					end
				endcase
			end
		end

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				wave[i]    <= 1'b0;
				wave_en[i] <= 1'b0;
			end else begin
				wave[i]    <= next_wave;
				wave_en[i] <= next_en;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = awready;
	assign s_axi_wready_o  = wready;
	assign s_axi_bvalid_o  = bvalid;
	assign s_axi_bresp_o   = bresp;
	assign s_axi_arready_o = arready;
	assign s_axi_rvalid_o  = rvalid;
	assign s_axi_rdata_o   = rdata;
	assign s_axi_rresp_o   = rresp;
	assign wave_out_a_o    = wave[0];
	assign wave_out_b_o    = wave[1];
	assign wave_en_a_o     = wave_en[0]; // R22
	assign wave_en_b_o     = wave_en[1];
	assign overflow_flag_o = ovf;
	assign match_flag_a_o  = mflag[0];
	assign match_flag_b_o  = mflag[1];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence normal_at_max;
		tick_eff && mode == timer8_pkg::MODE_NORMAL && cnt == timer8_pkg::MAX;
	endsequence
	sequence hit_a;
		tick_eff && cnt == cmp_act[0] && !block;
	endsequence

	normal_wrap_a: assert property (normal_at_max |=> cnt == timer8_pkg::BOTTOM && ovf) // R2
		else $error("normal mode did not wrap with overflow");
	ctc_clear_a: assert property (hit_a and mode == timer8_pkg::MODE_CTC |=> cnt == timer8_pkg::BOTTOM) // R4
		else $error("clear-on-match did not clear");
	fast_top_a: assert property (tick_eff && mode == timer8_pkg::MODE_FAST && at_top
		|=> cnt == timer8_pkg::BOTTOM && ovf) // R9
		else $error("fast mode top handling wrong");
	fast_set_a: assert property (tick_eff && mode == timer8_pkg::MODE_FAST && at_top
		&& act[0] == timer8_pkg::ACT_NONINV ##1 !tick_eff |-> wave[0]) // R10
		else $error("fast non-inverting not set at bottom");
	phase_turn_a: assert property (tick_eff && mode == timer8_pkg::MODE_PHASE && !dir_down && at_top
		&& cnt != timer8_pkg::BOTTOM |=> dir_down && cnt == $past(cnt) - 8'h01) // R16
		else $error("dual-slope turn wrong");
	phase_ovf_a: assert property (tick_eff && mode == timer8_pkg::MODE_PHASE && dir_down
		&& cnt == 8'h01 |=> ovf && cnt == timer8_pkg::BOTTOM) // R18
		else $error("dual-slope overflow missing at bottom");
	flag_next_a: assert property (hit_a |=> pend[0] ##0 (!tick_eff [*1] or tick_eff ##1 mflag[0])) // R23
		else $error("match flag not set on next tick");
	block_set_a: assert property (wr_count |=> block) // R24
		else $error("count write did not arm the match block");
	block_match_a: assert property (block && tick_eff |=> !pend[0] && !pend[1]) // R24
		else $error("match not blocked after count write");
	buffered_cmp_a: assert property (pwm && !(tick_eff && at_top) |=> $stable(cmp_act[0])) // R14
		else $error("pwm compare changed outside top");
	set_wins_a: assert property (tick_eff && ovf_ev && wr_status |=> ovf) // R3
		else $error("overflow lost against clear");
endmodule

// file: verif/wave_load.sv
// far-side load on one waveform pin, with pull-down
`timescale 1ns/1ps
module wave_load (
	input  wire logic wave_i,
	input  wire logic en_i,
	input  wire logic dir_i,
	output logic      pin_o
);
	// undriven pin sinks to the pull-down, never keeps the old wave level
	assign pin_o = (dir_i && en_i) ? wave_i : 1'b0;
endmodule

// file: verif/tb_top.sv
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst_n, tick, awvalid, wvalid, bready, arvalid, rready, dir_a;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [1:0]  bresp, rresp, rd_r, wr_r;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        wave_a, wave_b, en_a, en_b, ovf, mfa, mfb, pin_a;
	logic        inv;
	int          miscompares = 0;
	int          n_compared  = 0;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	timer8_waveform_modes timer8_waveform_modes_i (.clk_i(clk), .rst_n_i(rst_n), .timer_tick_i(tick),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.wave_out_a_o(wave_a), .wave_out_b_o(wave_b), .wave_en_a_o(en_a), .wave_en_b_o(en_b),
		.overflow_flag_o(ovf), .match_flag_a_o(mfa), .match_flag_b_o(mfb));

	wave_load wave_load_i (.wave_i(wave_a), .en_i(en_a), .dir_i(dir_a), .pin_o(pin_a));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				wr_r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rd_d = rdata;
				rd_r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// one-cycle tick pulses; ends off the edge so outputs have settled
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		@(negedge clk);
	endtask

	task automatic t_regs;
		rd(timer8_pkg::CTRL_OFS);
		chk("ctrl reset", rd_d, 32'h00000000);
		wr(5'h14, 8'h00);
		chk("unmapped wr resp", {30'h0, wr_r}, {30'h0, timer8_pkg::RESP_DECERR});
		rd(5'h14);
		chk("unmapped resp", {30'h0, rd_r}, {30'h0, timer8_pkg::RESP_DECERR});
		$display("test regs done");
	endtask

	// normal and reserved modes must wrap the same way
	task automatic t_wrap;
		logic [7:0] modes[3] = '{8'h00, 8'h04, 8'h06};
		foreach (modes[m]) begin
			wr(timer8_pkg::CTRL_OFS, modes[m]);
			wr(timer8_pkg::STATUS_OFS, 8'h07);
			wr(timer8_pkg::COUNT_OFS, 8'hFE);
			tk(1);
			rd(timer8_pkg::COUNT_OFS);
			chk("wrap count ff", rd_d, 32'h000000FF);
			chk("ovf early", {31'h0, ovf}, 32'h0);
			tk(1);
			rd(timer8_pkg::COUNT_OFS);
			chk("wrap count 00", rd_d, 32'h00000000);
			chk("ovf at zero", {31'h0, ovf}, 32'h1);
		end
		// tick held so the wrap meets the flag clear in one cycle: the set must win
		wr(timer8_pkg::COUNT_OFS, 8'hFD);
		@(posedge clk);
		tick <= 1'b1;
		wr(timer8_pkg::STATUS_OFS, 8'h07);
		tick <= 1'b0;
		tk(1);
		chk("set beats clear", {31'h0, ovf}, 32'h1);
		$display("test wrap done");
	endtask

	task automatic t_ctc;
		wr(timer8_pkg::CMPA_OFS, 8'h03);
		wr(timer8_pkg::CTRL_OFS, 8'h42);
		wr(timer8_pkg::STATUS_OFS, 8'h07);
		wr(timer8_pkg::COUNT_OFS, 8'h00);
		tk(4);
		rd(timer8_pkg::COUNT_OFS);
		chk("ctc clear", rd_d, 32'h0);
		chk("ctc toggle", {31'h0, wave_a}, 32'h1);
		chk("flag not yet", {31'h0, mfa}, 32'h0);
		tk(1);
		chk("flag next tick", {31'h0, mfa}, 32'h1);
		wr(timer8_pkg::COUNT_OFS, 8'h03);
		tk(1);
		rd(timer8_pkg::COUNT_OFS);
		chk("blocked match", rd_d, 32'h04);
		chk("no toggle", {31'h0, wave_a}, 32'h1);
		chk("flag b", {31'h0, mfb}, 32'h1);
		wr(timer8_pkg::CMPA_OFS, 8'h02);
		wr(timer8_pkg::STATUS_OFS, 8'h07);
		tk(252);
		rd(timer8_pkg::COUNT_OFS);
		chk("ran past", rd_d, 32'h0);
		chk("ctc ovf", {31'h0, ovf}, 32'h1);
		tk(3);
		rd(timer8_pkg::COUNT_OFS);
		chk("new top", rd_d, 32'h0);
		$display("test ctc done");
	endtask

	// non-inverting then inverting; compare held in buffer until top
	task automatic t_fast;
		for (int k = 0; k < 2; k++) begin
			inv = k[0];
			wr(timer8_pkg::CTRL_OFS, 8'h00);
			wr(timer8_pkg::CMPA_OFS, 8'h10);
			wr(timer8_pkg::CTRL_OFS, inv ? 8'hC3 : 8'h83);
			wr(timer8_pkg::STATUS_OFS, 8'h07);
			wr(timer8_pkg::COUNT_OFS, 8'hFF);
			tk(1);
			chk("fast ovf", {31'h0, ovf}, 32'h1);
			chk("bottom level", {31'h0, wave_a}, {31'h0, ~inv});
			rd(timer8_pkg::COUNT_OFS);
			chk("top to bottom", rd_d, 32'h0);
			chk("pin released", {31'h0, pin_a}, 32'h0);
			@(posedge clk);
			dir_a <= 1'b1;
			wr(timer8_pkg::CMPA_OFS, 8'h08);
			tk(16);
			chk("buffered cmp", {31'h0, wave_a}, {31'h0, ~inv});
			chk("pin drives", {31'h0, pin_a}, {31'h0, ~inv});
			tk(1);
			chk("match level", {31'h0, wave_a}, {31'h0, inv});
			dir_a <= 1'b0;
		end
		$display("test fast done");
	endtask

	task automatic t_phase;
		wr(timer8_pkg::CTRL_OFS, 8'hA1);
		wr(timer8_pkg::STATUS_OFS, 8'h07);
		wr(timer8_pkg::COUNT_OFS, 8'hFD);
		tk(2);
		rd(timer8_pkg::COUNT_OFS);
		chk("phase top", rd_d, 32'hFF);
		tk(1);
		rd(timer8_pkg::COUNT_OFS);
		chk("phase turn", rd_d, 32'hFE);
		chk("phase symmetry", {31'h0, wave_a}, 32'h0);
		tk(253);
		chk("no ovf yet", {31'h0, ovf}, 32'h0);
		chk("down match", {31'h0, wave_a}, 32'h1);
		tk(1);
		chk("ovf bottom", {31'h0, ovf}, 32'h1);
		tk(1);
		rd(timer8_pkg::COUNT_OFS);
		chk("up again", rd_d, 32'h01);
		chk("bottom cmp low", {31'h0, wave_b}, 32'h0);
		chk("b enabled", {31'h0, en_b}, 32'h1);
		tk(8);
		chk("up match", {31'h0, wave_a}, 32'h0);
		$display("test phase done");
	endtask

	// mode 7: compare A is top, A may toggle, B toggle is reserved
	task automatic t_toggle;
		wr(timer8_pkg::CTRL_OFS, 8'h00);
		wr(timer8_pkg::CMPA_OFS, 8'h03);
		wr(timer8_pkg::CTRL_OFS, 8'h57);
		wr(timer8_pkg::COUNT_OFS, 8'h00);
		tk(4);
		rd(timer8_pkg::COUNT_OFS);
		chk("top is cmp a", rd_d, 32'h0);
		chk("fast toggle", {31'h0, wave_a}, 32'h1);
		chk("b toggle off", {31'h0, en_b}, 32'h0);
		$display("test toggle done");
	endtask

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		{rst_n, tick, awvalid, wvalid, bready, arvalid, rready, dir_a} = 8'h00;
		{awaddr, araddr, wdata} = 42'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_wrap();
		t_ctc();
		t_fast();
		t_phase();
		t_toggle();
		print_verdict();
	end

	// about twenty times the expected run length
	initial begin
		#3000000;
		miscompares++;
		print_verdict();
	end
endmodule
